// [rtl/cap_pkg.sv]
// configuration, address map and power control constants and types
// assumes: single 50 MHz clock, isa-style 10-bit i/o addressing
package cap_pkg;
    // ======================================================
    // register indices and field positions
    localparam logic [7:0] CAP_IDX_FER = 8'h00;
    localparam logic [7:0] CAP_IDX_FAR = 8'h01;
    localparam logic [7:0] CAP_IDX_PTR = 8'h02;
    localparam int FER_PAR = 0, FER_SER1 = 1, FER_SER2 = 2, FER_FDC = 3;
    localparam int FER_ENC = 4, FER_FDC_SEC = 5;
    localparam int PTR_PD = 0, PTR_XTAL = 1, PTR_CSSEL = 2, PTR_IRQ7 = 3;
    localparam int PTR_TEST1 = 4, PTR_TEST2 = 5, PTR_LOCK = 6, PTR_PMODE = 7;
    // ======================================================
    // i/o addresses
    localparam logic [9:0] CAP_IDX_LO = 10'h398;
    localparam logic [9:0] CAP_IDX_HI = 10'h26E;
    localparam logic [9:0] CAP_DOR_PRI = 10'h3F2;
    localparam logic [9:0] CAP_DOR_SEC = 10'h372;
    localparam logic [9:0] CAP_FDC_PRI = 10'h3F0;
    localparam logic [9:0] CAP_FDC_SEC = 10'h370;
    localparam logic [9:0] CAP_PAR_A = 10'h378;
    localparam logic [9:0] CAP_PAR_B = 10'h3BC;
    localparam logic [9:0] CAP_PAR_C = 10'h278;
    localparam logic [9:0] CAP_SER_1 = 10'h3F8;
    localparam logic [9:0] CAP_SER_2 = 10'h2F8;
    localparam logic [79:0] CAP_SER_34 = {10'h228, 10'h220, 10'h2E0, 10'h2E8,
                                          10'h238, 10'h338, 10'h2E8, 10'h3E8};
    // ======================================================
    // reset values by strap pattern
    localparam logic [4:0] CAP_STRAP_NONE = 5'h1F;
    localparam logic [4:0] CAP_STRAP_FDC = 5'h1E;
    localparam logic [7:0] CAP_FER_NONE = 8'h00, CAP_PTR_NONE = 8'h02;
    localparam logic [7:0] CAP_FER_FDC = 8'h08, CAP_PTR_FDC = 8'h00;
    localparam logic [7:0] CAP_FER_DEF = 8'h0F, CAP_PTR_DEF = 8'h00;
    localparam logic [7:0] CAP_FAR_RST = 8'h10;
    localparam int IRQ3 = 0, IRQ4 = 1, IRQ5 = 2, IRQ7 = 3;
    // ======================================================
    // types
    typedef enum logic [0:0] {CAP_ST_STRAP = 1'b0, CAP_ST_RUN = 1'b1} cap_phase_t;
    typedef struct packed {
        cap_phase_t phase;
        logic [7:0] idx, function_enable_reg, function_address_map, ptr, dout;
        logic       wr_prev_b;
        logic [1:0] drv_sel;
        logic       mtr_a, mtr_b, serial_out_first, serial_out_second, cs_b;
        logic [3:0] irq_o, irq_oe;
    } cap_main_t;
    typedef struct packed {
        logic ser1_clk, ser2_clk, fdc_clk, xtal_run;
    } cap_pwr_t;
endpackage : cap_pkg

// [rtl/cap_cfg_if.sv]
// configuration register contents shared between the blocks
// assumes: driven only by the top register logic
`timescale 1ns/100ps
`default_nettype none
interface cap_cfg_if;
    logic [7:0] function_enable_reg;
    logic [7:0] function_address_map;
    logic [7:0] ptr;
    logic       power_down_pin_b;
    modport regs (output function_enable_reg, function_address_map, ptr, power_down_pin_b);
    modport user (input function_enable_reg, function_address_map, ptr, power_down_pin_b);
endinterface : cap_cfg_if
`default_nettype wire

// [rtl/cap_decode.sv]
// i/o range decoder for floppy, parallel and serial functions
// assumes: address stable while a strobe is low
`timescale 1ns/100ps
`default_nettype none
module cap_decode (
    cap_cfg_if.user         cfg,
    input  wire logic [9:0] addr,
    output logic            fdc_hit,
    output logic            dor_hit,
    output logic            par_hit,
    output logic            ser1_hit,
    output logic            ser2_hit
);
    // ======================================================
    // range functions
    function automatic logic [9:0] ser_base(input logic [1:0] code,
                                            input logic [1:0] sel34);
        logic [9:0] b;
        b = cap_pkg::CAP_SER_1;
        case (code)
            2'h0: b = cap_pkg::CAP_SER_1;
            2'h1: b = cap_pkg::CAP_SER_2;
            2'h2: b = cap_pkg::CAP_SER_34[{sel34, 1'b0}*10 +: 10];
            default: b = cap_pkg::CAP_SER_34[{sel34, 1'b1}*10 +: 10];
        endcase
        return b;
    endfunction : ser_base

    function automatic logic in8(input logic [9:0] a, input logic [9:0] b);
        return a[9:3] == b[9:3];
    endfunction : in8

    // ======================================================
    // decode, gated by function enables except the drive register hit
    always_comb begin
        fdc_hit  = cfg.function_enable_reg[cap_pkg::FER_FDC] && in8(addr, cfg.function_enable_reg[cap_pkg::FER_FDC_SEC] ?
                   cap_pkg::CAP_FDC_SEC : cap_pkg::CAP_FDC_PRI);
        dor_hit  = addr == (cfg.function_enable_reg[cap_pkg::FER_FDC_SEC] ?
                   cap_pkg::CAP_DOR_SEC : cap_pkg::CAP_DOR_PRI);
        ser1_hit = cfg.function_enable_reg[cap_pkg::FER_SER1]
                   && in8(addr, ser_base(cfg.function_address_map[3:2], cfg.function_address_map[7:6]));
        ser2_hit = cfg.function_enable_reg[cap_pkg::FER_SER2]
                   && in8(addr, ser_base(cfg.function_address_map[5:4], cfg.function_address_map[7:6]));
        par_hit  = 1'b0;
        // short range at 3BC only spans three bytes
        case (cfg.function_address_map[1:0])
            2'h0: par_hit = in8(addr, cap_pkg::CAP_PAR_A);
            2'h1: par_hit = addr[9:2] == cap_pkg::CAP_PAR_B[9:2] && addr[1:0] != 2'h3;
            2'h2: par_hit = in8(addr, cap_pkg::CAP_PAR_C);
            default: par_hit = 1'b0;
        endcase
        par_hit = par_hit && cfg.function_enable_reg[cap_pkg::FER_PAR];
    end
endmodule : cap_decode
`default_nettype wire

// [rtl/cap_power.sv]
// clock and crystal gating from enables, power bits and power-down pin
// assumes: low-power request from the floppy core is a level
`timescale 1ns/100ps
`default_nettype none
module cap_power (
    input  wire logic clk,
    input  wire logic rst_b,
    cap_cfg_if.user   cfg,
    input  wire logic fdc_floppy_low_power_cmd,
    output var cap_pkg::cap_pwr_t gate
);
    cap_pkg::cap_pwr_t st_q, st_d;
    logic pd_req, none_on, xtal_stop, all_stop;

    // ======================================================
    // power-down decision
    always_comb begin
        pd_req    = cfg.ptr[cap_pkg::PTR_PD]
                    || (!cfg.ptr[cap_pkg::PTR_CSSEL] && !cfg.power_down_pin_b);
        none_on   = !(cfg.function_enable_reg[cap_pkg::FER_SER1] || cfg.function_enable_reg[cap_pkg::FER_SER2]
                    || cfg.function_enable_reg[cap_pkg::FER_FDC]);
        xtal_stop = none_on || (cfg.ptr[cap_pkg::PTR_XTAL]
                    && (pd_req || fdc_floppy_low_power_cmd));
        all_stop  = pd_req || xtal_stop;
        st_d.ser1_clk = cfg.function_enable_reg[cap_pkg::FER_SER1] && !all_stop;
        st_d.ser2_clk = cfg.function_enable_reg[cap_pkg::FER_SER2] && !all_stop;
        st_d.fdc_clk  = cfg.function_enable_reg[cap_pkg::FER_FDC] && !all_stop && !fdc_floppy_low_power_cmd;
        st_d.xtal_run = !xtal_stop;
    end

    // registers untouched by power state so contents survive stops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign gate = st_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    disabled_no_clk_a: assert property (!cfg.function_enable_reg[cap_pkg::FER_FDC] |=> !gate.fdc_clk)
        else $error("disabled floppy has a clock");
    xtal_bit0_a: assert property (cfg.ptr[1] && cfg.ptr[0] |=> !gate.xtal_run)
        else $error("crystal runs with bit 1 and bit 0 set");
    clk_only_a: assert property (!cfg.ptr[1] && cfg.ptr[0] && cfg.function_enable_reg[1]
                                 |=> !gate.ser1_clk && gate.xtal_run)
        else $error("clock-only power-down wrong");
endmodule : cap_power
`default_nettype wire

// [rtl/cap_top.sv]
// configuration register bank: index/data access, drive encoding,
// interrupt routing, serial test mode and power gating outputs
// assumes: isa strobes active low, synchronous to SYS_CLK, held for
// several cycles; straps stable across reset release
`timescale 1ns/100ps
`default_nettype none
module cap_top (
    input  wire logic       SYS_CLK,
    input  wire logic       RST_B,
    input  wire logic [9:0] IO_ADDR,
    input  wire logic [7:0] IO_DIN,
    input  wire logic       IO_WRITE_STROBE_B,
    input  wire logic       IO_READ_STROBE_B,
    output logic [7:0]      IO_DOUT,
    output logic            IO_DOE,
    input  wire logic [4:0] CONFIG_STRAP_PINS,
    input  wire logic       INDEX_BASE_STRAP,
    input  wire logic       PARALLEL_MODE_STRAP,
    input  wire logic       XT_MODE,
    input  wire logic [7:0] DRIVE_OUTPUT_REG,
    input  wire logic [1:0] FDC_DRIVE_SEL,
    input  wire logic [1:0] FDC_MOTOR,
    input  wire logic       FLOPPY_LOW_POWER_CMD,
    output logic            DRIVE_SEL_A,
    output logic            DRIVE_SEL_B,
    output logic            MOTOR_OUT_A,
    output logic            MOTOR_OUT_B,
    input  wire logic       PD_CS_I,
    output logic            PD_CS_O,
    output logic            PD_CS_OE,
    input  wire logic       SER1_SOUT,
    input  wire logic       SER1_BAUD,
    input  wire logic       SER1_LCR7,
    input  wire logic       SER2_SOUT,
    input  wire logic       SER2_BAUD,
    input  wire logic       SER2_LCR7,
    output logic            SERIAL_OUT_FIRST,
    output logic            SERIAL_OUT_SECOND,
    input  wire logic       PAR_IRQ,
    input  wire logic       SER1_IRQ,
    input  wire logic       SER2_IRQ,
    output logic [3:0]      IRQ_O,
    output logic [3:0]      IRQ_OE,
    output logic            FDC_SEL,
    output logic            PAR_SEL,
    output logic            SER1_SEL,
    output logic            SER2_SEL,
    output logic            PAR_EXTENDED,
    output logic            SER1_CLK_EN,
    output logic            SER2_CLK_EN,
    output logic            FDC_CLK_EN,
    output logic            XTAL_EN
);
    cap_pkg::cap_main_t st_q, st_d;
    cap_pkg::cap_pwr_t  gate;
    cap_cfg_if          cfg ();
    logic [9:0] idx_addr;
    logic       idx_hit, dat_hit, wr_edge, enc;
    logic       fdc_hit, dor_hit, par_hit, ser1_hit, ser2_hit;

    // ======================================================
    // helpers
    function automatic logic [7:0] reg_read(input cap_pkg::cap_main_t s);
        logic [7:0] v;
        v = 8'h00;
        if (s.idx == cap_pkg::CAP_IDX_FER) begin
            v = s.function_enable_reg;
        end else if (s.idx == cap_pkg::CAP_IDX_FAR) begin
            v = s.function_address_map;
        end else if (s.idx == cap_pkg::CAP_IDX_PTR) begin
            v = s.ptr;
        end
        return v;
    endfunction : reg_read

    // serial ports 1 and 3 share IRQ4, ports 2 and 4 IRQ3
    function automatic logic [3:0] ser_irq(input logic [1:0] code);
        return code[0] ? 4'h1 : 4'h2;
    endfunction : ser_irq

    // ======================================================
    // submodules
    assign cfg.function_enable_reg    = st_q.function_enable_reg;
    assign cfg.function_address_map    = st_q.function_address_map;
    assign cfg.ptr    = st_q.ptr;
    assign cfg.power_down_pin_b = PD_CS_I;

    cap_decode u_dec (
        .cfg      (cfg),
        .addr     (IO_ADDR),
        .fdc_hit  (fdc_hit),
        .dor_hit  (dor_hit),
        .par_hit  (par_hit),
        .ser1_hit (ser1_hit),
        .ser2_hit (ser2_hit)
    );

    cap_power u_pwr (
        .clk         (SYS_CLK),
        .rst_b       (RST_B),
        .cfg         (cfg),
        .fdc_floppy_low_power_cmd (FLOPPY_LOW_POWER_CMD),
        .gate        (gate)
    );

    // ======================================================
    // bus decode
    assign idx_addr = INDEX_BASE_STRAP ? cap_pkg::CAP_IDX_HI : cap_pkg::CAP_IDX_LO;
    assign idx_hit  = IO_ADDR == idx_addr;
    assign dat_hit  = IO_ADDR == idx_addr + 10'h001;
    assign wr_edge  = !IO_WRITE_STROBE_B && st_q.wr_prev_b;
    assign enc      = st_q.function_enable_reg[cap_pkg::FER_ENC];

    // ======================================================
    // next state
    always_comb begin
        logic [3:0] par_line;
        par_line = 4'h0;
        st_d = st_q;
        st_d.phase = cap_pkg::CAP_ST_RUN;
        st_d.wr_prev_b = IO_WRITE_STROBE_B;
        case (st_q.phase)
            // straps caught on the first edge after release, not under reset
            cap_pkg::CAP_ST_STRAP: begin
                st_d.function_address_map = cap_pkg::CAP_FAR_RST;
                if (CONFIG_STRAP_PINS == cap_pkg::CAP_STRAP_NONE) begin
                    st_d.function_enable_reg = cap_pkg::CAP_FER_NONE;
                    st_d.ptr = cap_pkg::CAP_PTR_NONE;
                end else if (CONFIG_STRAP_PINS == cap_pkg::CAP_STRAP_FDC) begin
                    st_d.function_enable_reg = cap_pkg::CAP_FER_FDC;
                    st_d.ptr = cap_pkg::CAP_PTR_FDC;
                end else begin
                    st_d.function_enable_reg = cap_pkg::CAP_FER_DEF;
                    st_d.ptr = cap_pkg::CAP_PTR_DEF;
                end
                st_d.ptr[cap_pkg::PTR_PMODE] = !PARALLEL_MODE_STRAP;
            end
            default: begin
                if (wr_edge && idx_hit) begin
                    st_d.idx = IO_DIN;
                end
                // lock is sticky: only reset clears it
                if (wr_edge && dat_hit && !st_q.ptr[cap_pkg::PTR_LOCK]) begin
                    if (st_q.idx == cap_pkg::CAP_IDX_FER) begin
                        st_d.function_enable_reg = IO_DIN;
                    end else if (st_q.idx == cap_pkg::CAP_IDX_FAR) begin
                        st_d.function_address_map = IO_DIN;
                    end else if (st_q.idx == cap_pkg::CAP_IDX_PTR) begin
                        st_d.ptr = IO_DIN;
                    end
                end
            end
        endcase
        st_d.dout = dat_hit ? reg_read(st_q) : st_q.idx;
        // drive pins: encoded for external decoder or passed straight
        if (enc) begin
            st_d.drv_sel = DRIVE_OUTPUT_REG[1:0];
            st_d.mtr_a   = !DRIVE_OUTPUT_REG[3'h4 + {1'b0, DRIVE_OUTPUT_REG[1:0]}];
            st_d.mtr_b   = !IO_WRITE_STROBE_B && dor_hit;
        end else begin
            st_d.drv_sel = FDC_DRIVE_SEL;
            st_d.mtr_a   = FDC_MOTOR[0];
            st_d.mtr_b   = FDC_MOTOR[1];
        end
        // baud clock replaces the serial output only in test mode
        st_d.serial_out_first = (st_q.ptr[cap_pkg::PTR_TEST1] && SER1_LCR7) ? SER1_BAUD : SER1_SOUT;
        st_d.serial_out_second = (st_q.ptr[cap_pkg::PTR_TEST2] && SER2_LCR7) ? SER2_BAUD : SER2_SOUT;
        st_d.cs_b  = !par_hit;
        // interrupt routing
        case (st_q.function_address_map[1:0])
            2'h0: par_line = (XT_MODE || st_q.ptr[cap_pkg::PTR_IRQ7]) ? 4'h8 : 4'h4;
            2'h1: par_line = 4'h8;
            2'h2: par_line = XT_MODE ? 4'h8 : 4'h4;
            default: par_line = 4'h0;
        endcase
        par_line = st_q.function_enable_reg[cap_pkg::FER_PAR] ? par_line : 4'h0;
        st_d.irq_oe = par_line
                    | (st_q.function_enable_reg[cap_pkg::FER_SER1] ? ser_irq(st_q.function_address_map[3:2]) : 4'h0)
                    | (st_q.function_enable_reg[cap_pkg::FER_SER2] ? ser_irq(st_q.function_address_map[5:4]) : 4'h0);
        st_d.irq_o  = (PAR_IRQ ? par_line : 4'h0)
                    | ((SER1_IRQ && st_q.function_enable_reg[cap_pkg::FER_SER1]) ? ser_irq(st_q.function_address_map[3:2]) : 4'h0)
                    | ((SER2_IRQ && st_q.function_enable_reg[cap_pkg::FER_SER2]) ? ser_irq(st_q.function_address_map[5:4]) : 4'h0);
    end

    // ======================================================
    // state register
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_q <= '{phase: cap_pkg::CAP_ST_STRAP, wr_prev_b: 1'b1, mtr_a: 1'b1,
                      cs_b: 1'b1, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // ======================================================
    // outputs
    assign IO_DOUT           = st_q.dout;
    assign IO_DOE            = !IO_READ_STROBE_B && (idx_hit || dat_hit);
    assign DRIVE_SEL_A       = st_q.drv_sel[0];
    assign DRIVE_SEL_B       = st_q.drv_sel[1];
    assign MOTOR_OUT_A       = st_q.mtr_a;
    assign MOTOR_OUT_B       = st_q.mtr_b;
    assign PD_CS_O           = st_q.cs_b;
    assign PD_CS_OE          = st_q.ptr[cap_pkg::PTR_CSSEL];
    assign SERIAL_OUT_FIRST  = st_q.serial_out_first;
    assign SERIAL_OUT_SECOND = st_q.serial_out_second;
    assign IRQ_O             = st_q.irq_o;
    assign IRQ_OE            = st_q.irq_oe;
    assign FDC_SEL           = fdc_hit;
    assign PAR_SEL           = par_hit;
    assign SER1_SEL          = ser1_hit;
    assign SER2_SEL          = ser2_hit;
    assign PAR_EXTENDED      = st_q.ptr[cap_pkg::PTR_PMODE];
    assign SER1_CLK_EN       = gate.ser1_clk;
    assign SER2_CLK_EN       = gate.ser2_clk;
    assign FDC_CLK_EN        = gate.fdc_clk;
    assign XTAL_EN           = gate.xtal_run;

    // ======================================================
    // checks
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    sequence s_cfg_write;
        st_q.phase == cap_pkg::CAP_ST_RUN && wr_edge && dat_hit;
    endsequence
    sequence s_dor_write;
        enc && !IO_WRITE_STROBE_B && dor_hit;
    endsequence

    lock_holds_regs_a: assert property (s_cfg_write and st_q.ptr[6]
                                        |=> $stable({st_q.function_enable_reg, st_q.function_address_map, st_q.ptr}))
        else $error("write accepted while locked");
    dor_pulse_out_a: assert property (s_dor_write |=> MOTOR_OUT_B)
        else $error("no motor pulse on drive register write");
    enc_drive_sel_a: assert property (enc |=> {DRIVE_SEL_B, DRIVE_SEL_A}
                                      == $past(DRIVE_OUTPUT_REG[1:0]))
        else $error("encoded drive number wrong");
    enc_motor_a: assert property (enc && DRIVE_OUTPUT_REG == 8'h10 |=> !MOTOR_OUT_A)
        else $error("motor not active for drive 0");
    par_irq7_a: assert property (st_q.function_enable_reg[0] && st_q.function_address_map[1:0] == 2'h0 && st_q.ptr[3]
                                 |=> IRQ_OE[3] && !IRQ_OE[2])
        else $error("parallel interrupt not on IRQ7");
    par_reserved_a: assert property (st_q.function_address_map[1:0] == 2'h3 |=> !IRQ_OE[3] && !IRQ_OE[2]
                                     && !PAR_SEL)
        else $error("reserved parallel code still active");
    strap_all_high_a: assert property (st_q.phase == cap_pkg::CAP_ST_STRAP
                                       && CONFIG_STRAP_PINS == 5'h1F
                                       |=> st_q.function_enable_reg == 8'h00 ##1 !XTAL_EN)
        else $error("all-high straps did not stop crystal");
    mode_strap_a: assert property (st_q.phase == cap_pkg::CAP_ST_STRAP
                                   |=> PAR_EXTENDED == !$past(PARALLEL_MODE_STRAP))
        else $error("parallel mode not strap inverse");
    test_baud_a: assert property (st_q.ptr[4] && SER1_LCR7
                                  |=> SERIAL_OUT_FIRST == $past(SER1_BAUD))
        else $error("baud clock not on serial output");
    pin_role_a: assert property (PD_CS_OE == st_q.ptr[2])
        else $error("shared pin role wrong");
endmodule : cap_top
`default_nettype wire

// [sim/cap_drive_latch.sv]
// external drive decoder latch for encoded four-drive mode
// assumes: clocked by the rising edge of the second motor pin
`timescale 1ns/100ps
`default_nettype none
module cap_drive_latch (
    input  wire logic  drv_a,
    input  wire logic  drv_b,
    input  wire logic  mtr_a,
    input  wire logic  strobe,
    output logic [2:0] held_q
);
    // ======================================================
    // capture
    // pins must be settled before the strobe rises, else a stale drive is taken
    always_ff @(posedge strobe) begin
        held_q <= {drv_b, drv_a, mtr_a};
    end
endmodule : cap_drive_latch
`default_nettype wire

// [sim/config_addr_power_ctrl_test.sv]
// self-checking bench for the configuration register bank
// assumes: index pair at 398h, all straps low, latch model on drive pins
`timescale 1ns/100ps
`default_nettype none
module config_addr_power_ctrl_test;
    logic       SYS_CLK = '0, RST_B = '0, IO_WRITE_STROBE_B = 1'h1, IO_READ_STROBE_B = 1'h1;
    logic       INDEX_BASE_STRAP = '0, PARALLEL_MODE_STRAP = '0, XT_MODE = '0, PD_CS_I = 1'h1;
    logic       FLOPPY_LOW_POWER_CMD = '0, SER1_SOUT = '0, SER1_BAUD = '0, SER1_LCR7 = '0;
    logic       SER2_SOUT = '0, SER2_BAUD = '0, SER2_LCR7 = '0, PAR_IRQ = '0, SER1_IRQ = '0;
    logic       SER2_IRQ = '0;
    logic [9:0] IO_ADDR = '0;
    logic [7:0] IO_DIN = '0, DRIVE_OUTPUT_REG = '0, d;
    logic [4:0] CONFIG_STRAP_PINS = '0;
    logic [1:0] FDC_DRIVE_SEL = '0, FDC_MOTOR = '0;
    wire  [7:0] IO_DOUT;
    wire  [3:0] IRQ_O, IRQ_OE;
    wire  [2:0] held;
    wire        DRIVE_SEL_A, DRIVE_SEL_B, MOTOR_OUT_A, MOTOR_OUT_B, SERIAL_OUT_FIRST, PAR_SEL;
    wire        SER1_SEL, SER2_SEL, PAR_EXTENDED, SER1_CLK_EN, SER2_CLK_EN, FDC_CLK_EN, XTAL_EN;
    wire        IO_DOE, PD_CS_O, PD_CS_OE, SERIAL_OUT_SECOND, FDC_SEL;
    int         err_count = 0, total_checks = 0, cycles = 0, seed = 32'h9B0A, i;
    logic [9:0] third [4] = '{10'h3E8, 10'h338, 10'h2E8, 10'h220};
    logic [9:0] fourth [4] = '{10'h2E8, 10'h238, 10'h2E0, 10'h228};
    cap_top u_dut (.SYS_CLK, .RST_B, .IO_ADDR, .IO_DIN, .IO_WRITE_STROBE_B, .IO_READ_STROBE_B,
        .IO_DOUT, .IO_DOE, .CONFIG_STRAP_PINS, .INDEX_BASE_STRAP, .PARALLEL_MODE_STRAP,
        .XT_MODE, .DRIVE_OUTPUT_REG, .FDC_DRIVE_SEL, .FDC_MOTOR, .FLOPPY_LOW_POWER_CMD,
        .DRIVE_SEL_A, .DRIVE_SEL_B, .MOTOR_OUT_A, .MOTOR_OUT_B, .PD_CS_I, .PD_CS_O,
        .PD_CS_OE, .SER1_SOUT, .SER1_BAUD, .SER1_LCR7, .SER2_SOUT, .SER2_BAUD, .SER2_LCR7,
        .SERIAL_OUT_FIRST, .SERIAL_OUT_SECOND, .PAR_IRQ, .SER1_IRQ, .SER2_IRQ, .IRQ_O,
        .IRQ_OE, .FDC_SEL, .PAR_SEL, .SER1_SEL, .SER2_SEL, .PAR_EXTENDED, .SER1_CLK_EN,
        .SER2_CLK_EN, .FDC_CLK_EN, .XTAL_EN);
    cap_drive_latch u_latch (.drv_a(DRIVE_SEL_A), .drv_b(DRIVE_SEL_B), .mtr_a(MOTOR_OUT_A),
        .strobe(MOTOR_OUT_B), .held_q(held));
    // ======================================================
    // clock and hang guard
    always #10 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            summarize();
        end
    end
    // ======================================================
    // bus tasks, strobe held one full cycle then released
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(negedge SYS_CLK);
        IO_ADDR = a;
        IO_DIN = v;
        IO_WRITE_STROBE_B = '0;
        @(negedge SYS_CLK);
        IO_WRITE_STROBE_B = 1'h1;
        @(negedge SYS_CLK);
    endtask : wr
    task automatic wreg(input logic [7:0] x, input logic [7:0] v);
        wr(10'h398, x);
        wr(10'h399, v);
    endtask : wreg
    task automatic rdreg(input logic [7:0] x, output logic [7:0] v);
        wr(10'h398, x);
        IO_ADDR = 10'h399;
        IO_READ_STROBE_B = '0;
        repeat (2) @(negedge SYS_CLK);
        v = IO_DOUT;
        chk("doe", 8'h01, {7'h0, IO_DOE});
        IO_READ_STROBE_B = 1'h1;
    endtask : rdreg
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic pw(input logic [7:0] p, input logic [3:0] e);
        wreg(8'h02, p);
        repeat (2) @(negedge SYS_CLK);
        chk("clocks", {4'h0, e}, {4'h0, SER1_CLK_EN, SER2_CLK_EN, FDC_CLK_EN, XTAL_EN});
    endtask : pw
    // expected {irq7, irq5} enables for the parallel port
    function automatic logic [1:0] par_exp(input logic [1:0] c, input logic b3, input logic xt);
        if (c == 2'h3) return 2'h0;
        return (xt || c == 2'h1 || (c == 2'h0 && b3)) ? 2'h2 : 2'h1;
    endfunction : par_exp
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    // ======================================================
    // main sequence
    initial begin
        repeat (5) @(negedge SYS_CLK);
        RST_B = 1'h1;
        repeat (2) @(negedge SYS_CLK);
        rdreg(8'h01, d);
        chk("far", 8'h10, d);
        rdreg(8'h02, d);
        chk("ptr", 8'h80, d);
        chk("pmode", 8'h01, {7'h0, PAR_EXTENDED});
        PAR_IRQ = 1'h1;
        for (i = 0; i < 16; i++) begin
            XT_MODE = i[3];
            wreg(8'h02, {4'h0, i[2], 3'h0});
            wreg(8'h01, {6'h04, i[1:0]});
            IO_ADDR = (i[1:0] == 2'h1) ? 10'h3BC : (i[1] ? 10'h278 : 10'h378);
            repeat (2) @(negedge SYS_CLK);
            chk("par irq", {4'h0, {2{par_exp(i[1:0], i[2], i[3])}}},
                {4'h0, IRQ_OE[3:2], IRQ_O[3:2] & IRQ_OE[3:2]});
            chk("par sel", {7'h0, i[1:0] != 2'h3}, {7'h0, PAR_SEL});
        end
        for (i = 0; i < 16; i++) begin
            wreg(8'h01, {i[3:2], ~i[1:0], i[1:0], 2'h0});
            IO_ADDR = (i[1:0] == 2'h0) ? 10'h3F8 : (i[1:0] == 2'h1) ? 10'h2F8
                    : i[0] ? fourth[i[3:2]] : third[i[3:2]];
            #1 chk("ser1 sel", 8'h01, {7'h0, SER1_SEL});
            IO_ADDR = (i[1:0] == 2'h3) ? 10'h3F8 : (i[1:0] == 2'h2) ? 10'h2F8
                    : i[0] ? third[i[3:2]] : fourth[i[3:2]];
            #1 chk("ser2 sel", 8'h01, {7'h0, SER2_SEL});
        end
        wreg(8'h00, 8'h1F);
        for (i = 0; i < 6; i++) begin
            d = $random(seed);
            DRIVE_OUTPUT_REG = d;
            wr(10'h3F2, d);
            chk("drive", {5'h0, d[1:0], ~d[3'h4 + d[1:0]]}, {5'h0, held});
        end
        wreg(8'h02, 8'h10);
        SER1_LCR7 = 1'h1;
        for (i = 0; i < 8; i++) begin
            SER1_BAUD = $random(seed);
            SER2_SOUT = $random(seed);
            @(negedge SYS_CLK);
            chk("sout", {7'h0, SER1_BAUD}, {7'h0, SERIAL_OUT_FIRST});
            chk("serial_out_second", {7'h0, SER2_SOUT}, {7'h0, SERIAL_OUT_SECOND});
        end
        wreg(8'h00, 8'h0D);
        pw(8'h00, 4'h7);
        pw(8'h01, 4'h1);
        pw(8'h03, 4'h0);
        // clock-only stops below need no crystal settling wait
        PD_CS_I = '0;
        pw(8'h00, 4'h1);
        PD_CS_I = 1'h1;
        FLOPPY_LOW_POWER_CMD = 1'h1;
        pw(8'h00, 4'h5);
        IO_ADDR = 10'h3F0;
        #1 chk("fdc sel", 8'h01, {7'h0, FDC_SEL});
        wreg(8'h02, 8'h04);
        IO_ADDR = 10'h378;
        repeat (2) @(negedge SYS_CLK);
        chk("cs pin", 8'h02, {6'h0, PD_CS_OE, PD_CS_O});
        wreg(8'h02, 8'h40);
        wreg(8'h01, 8'h55);
        rdreg(8'h01, d);
        chk("locked far", 8'hCC, d);
        summarize();
    end
endmodule : config_addr_power_ctrl_test
`default_nettype wire
